// *** hdl/seq_pkg.sv ***
// Constants shared by the converter sequencer and its result arithmetic.
package seq_pkg;
	localparam int          CLK_HZ            = 25000000;
	// Conversion periods, in ns, selectable per channel.
	localparam int          CT_MIN_NS         = 50000;
	localparam int          CT_MAX_NS         = 4120000;
	localparam int          CT_MIN_CYC        = (CT_MIN_NS * 25 + 999) / 1000;
	localparam int          CT_MAX_CYC        = (CT_MAX_NS * 25) / 1000;
	// Start delay step in ms and the derived count of cycles per step.
	localparam int          DLY_STEP_MS       = 2;
	localparam int          DLY_STEP_CYC      = DLY_STEP_MS * (CLK_HZ / 1000);
	localparam int          DLY_MAX_STEPS     = 255;
	localparam int          AVG_MAX           = 1024;
	localparam int          TEMPCO_FULL_SCALE = 16384;
	localparam int          TREF_DEG          = 25;
	// Register byte addresses.
	localparam logic [7:0]  ADDR_CONFIG       = 8'h00;
	localparam logic [7:0]  ADDR_ADC_SETUP    = 8'h04;
	localparam logic [7:0]  ADDR_SHUNT_CAL    = 8'h08;
	localparam logic [7:0]  ADDR_TEMPCO       = 8'h0c;
	localparam logic [7:0]  ADDR_SHUNT_RES    = 8'h10;
	localparam logic [7:0]  ADDR_BUS_RES      = 8'h14;
	localparam logic [7:0]  ADDR_TEMP_RES     = 8'h18;
	localparam logic [7:0]  ADDR_CURRENT      = 8'h1c;
	localparam logic [7:0]  ADDR_POWER        = 8'h20;
	localparam logic [7:0]  ADDR_ENERGY       = 8'h24;
	localparam logic [7:0]  ADDR_CHARGE       = 8'h28;
	localparam logic [7:0]  ADDR_DIAG         = 8'h2c;
	localparam logic [7:0]  ADDR_STATUS       = 8'h30;
	// Configuration fields: start delay [13:6], compensation enable [5].
	localparam int          CFG_DLY_LSB       = 6;
	localparam int          CFG_COMP_BIT      = 5;
	// Converter setup fields: mode [15:12], avg code [11:9], periods 3x3 bits.
	localparam int          ADC_MODE_LSB      = 12;
	localparam int          ADC_AVG_LSB       = 9;
	localparam int          ADC_VSH_LSB       = 3;
	localparam int          ADC_VBUS_LSB      = 6;
	localparam int          ADC_VT_LSB        = 0;
	localparam logic [15:0] ADC_SETUP_RESET   = 16'hfb68;
	localparam int          DIAG_DONE_BIT     = 1;
	localparam logic [1:0]  RESP_OKAY         = 2'b00;
	localparam logic [1:0]  RESP_SLVERR       = 2'b10;
	// Mode: bit3 continuous, bits2..0 enable temperature, shunt, bus.
	localparam int          MODE_CONT_BIT     = 3;
	localparam int          MODE_TEMP_BIT     = 2;
	localparam int          MODE_SHUNT_BIT    = 1;
	localparam int          MODE_BUS_BIT      = 0;
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_DELAY = 3'b001,
		ST_CONV  = 3'b011,
		ST_NEXT  = 3'b010,
		ST_LOAD  = 3'b110
	} seq_state_e;
endpackage : seq_pkg

// *** hdl/result_math.sv ***
// Background current, power, energy and charge arithmetic with drift compensation.
module result_math
	import seq_pkg::*;
(
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               shunt_upd,
	input  wire logic               bus_upd,
	input  wire logic               cont_mode,
	input  wire logic               comp_en,
	input  wire logic signed [19:0] shunt_res,
	input  wire logic signed [19:0] bus_res,
	input  wire logic signed [15:0] temp_res,
	input  wire logic [15:0]        shunt_cal,
	input  wire logic [13:0]        tempco,
	output logic signed [23:0]      current_r,
	output logic [23:0]             power_r,
	output logic [31:0]             energy_r,
	output logic [31:0]             charge_r
);
	// Temperature in whole degrees (register holds 1/128 degree steps).
	wire logic signed [15:0] deg_c       = temp_res >>> 7;
	wire logic signed [15:0] dt          = deg_c - 16'(TREF_DEG);
	// Coefficient is always taken as positive.
	wire logic signed [31:0] drift_ppm   = dt * $signed({2'b00, tempco}); // RULE19
	wire logic signed [47:0] cal_ext     = $signed({16'h0000, shunt_cal});
	wire logic signed [47:0] cal_adj     = cal_ext + ((cal_ext * drift_ppm) / 48'sd1000000);
	wire logic signed [47:0] cal_eff     = comp_en ? cal_adj : cal_ext; // RULE18
	// Current is the shunt result times 16384, divided by the effective resistance.
	wire logic signed [47:0] cur_full    = (cal_eff == 48'sd0) ? 48'sd0 :
		($signed({{28{shunt_res[19]}}, shunt_res}) * 48'sd16384) / cal_eff;
	wire logic signed [23:0] cur_nxt     = cur_full[23:0];
	wire logic [47:0]        pow_full    = 48'($signed(current_r) * bus_res);
	wire logic [23:0]        power_nxt   = (shunt_cal == 16'h0000) ? 24'h000000 : pow_full[43:20];
	wire logic               cal_zero    = (shunt_cal == 16'h0000);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			current_r <= 24'sh000000;
		else if (shunt_upd || comp_en) // RULE20
			current_r <= cur_nxt;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cal_zero) // RULE21
		begin
			power_r  <= 24'h000000;
			energy_r <= 32'h00000000;
			charge_r <= 32'h00000000;
		end
		else
		begin
			if (bus_upd) // RULE22
			begin
				power_r  <= power_nxt;
				// Accumulation only counts time in continuous mode.
				if (cont_mode) // RULE13
					energy_r <= energy_r + {8'h00, power_nxt};
			end
			if (shunt_upd && cont_mode) // RULE12
				charge_r <= charge_r + 32'($signed(current_r));
		end
	end
endmodule : result_math

// *** hdl/power_monitor_adc_sequencer.sv ***
// Converter sequencer of a current/voltage/power monitor with AXI4-Lite registers.
// Function
// RULE1: Convert any chosen mix of shunt, bus and temperature channels.
// RULE2: With averaging one, each result updates as its conversion ends.
// RULE3: Conversion period is programmed separately per channel, 50 us to 4.12 ms.
// RULE4: Enabled channels convert in sequence; total is sum of periods.
// RULE5: Averaging accumulates and repeats sequences, then writes final results.
// RULE6: Results hold until replaced; reads never disturb conversion.
// RULE7: Continuous mode repeats sequences without further command.
// RULE8: Triggered mode runs one full sequence then shuts down.
// RULE9: Writing the mode field aborts and restarts conversion; here only setup writes strobing byte lanes 0 and 1 restart.
// RULE10: Done flag sets only after all conversions and averaging finish.
// RULE11: Done flag clears on diagnostic read or non-shutdown setup write.
// RULE12: Current, power, charge, energy computed in background.
// RULE13: Energy and charge do not accumulate in triggered mode.
// RULE14: Start delay programmable 0 to 510 ms in 2 ms steps, reset zero.
// RULE15: Filter adapts to period, settles within one conversion.
// RULE16: Averaging 1 to 1024, same count for all channels.
// RULE17: Die temperature result stored in a readable register.
// RULE18: Compensation enable applies the programmed drift coefficient.
// RULE19: Adjusted resistance is nominal scaled by (temp-25)*coeff/1e6.
// RULE20: With compensation on, current recomputes with latest temperature.
// RULE21: Power, energy and charge read zero when calibration is zero.
// RULE22: Power and energy follow each bus measurement.
// RULE23: Start delay applies once after a mode write.
module power_monitor_adc_sequencer
	import seq_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [19:0] adc_sample,
	output logic [1:0]       adc_channel,
	output logic             adc_active
);
	seq_state_e state_r;
	seq_state_e state_nxt;

	logic [15:0] config_r;
	logic [15:0] adc_setup_r;
	logic [15:0] shunt_cal_r;
	logic [13:0] tempco_r;
	logic [19:0] shunt_res_r;
	logic [19:0] bus_res_r;
	logic [15:0] temp_res_r;
	logic        done_flag_r;
	logic        shunt_upd_r;
	logic        bus_upd_r;
	logic [7:0]  awaddr_r;
	logic        aw_held_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        w_held_r;
	logic [17:0] ct_cnt_r;
	logic [19:0] dly_cnt_r;
	logic [7:0]  dly_steps_r;
	logic [1:0]  chan_r;
	logic [10:0] avg_cnt_r;
	logic [29:0] acc_r [3];
	logic [19:0] din_r [2];

	// Pin sample crosses in from the analog clock, so it is synchronised.
	always_ff @(posedge aclk)
	begin
		din_r[0] <= adc_sample;
		din_r[1] <= din_r[0];
	end

	// Write channel: address and data taken in either order.
	wire logic        wr_go       = aw_held_r && w_held_r && !s_axi_bvalid;
	wire logic        wr_setup    = wr_go && (awaddr_r == ADDR_ADC_SETUP) && (&wstrb_r[1:0]);
	wire logic [3:0]  new_mode    = wdata_r[ADC_MODE_LSB +: 4];
	wire logic        new_shut    = (new_mode[2:0] == 3'b000);
	wire logic        wr_known    = (awaddr_r == ADDR_CONFIG) || (awaddr_r == ADDR_ADC_SETUP) ||
		(awaddr_r == ADDR_SHUNT_CAL) || (awaddr_r == ADDR_TEMPCO);
	wire logic        rd_go       = s_axi_arvalid && s_axi_arready;
	wire logic        rd_diag     = rd_go && (s_axi_araddr == ADDR_DIAG);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h00000000;
			wstrb_r       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes with byte lanes.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			config_r    <= 16'h0000; // RULE14
			adc_setup_r <= ADC_SETUP_RESET;
			shunt_cal_r <= 16'h0000;
			tempco_r    <= 14'h0000;
		end
		else if (wr_go)
		begin
			for (int b = 0; b < 2; b++)
			begin
				if (wstrb_r[b] && awaddr_r == ADDR_CONFIG)
					config_r[8*b +: 8] <= wdata_r[8*b +: 8];
				if (wstrb_r[b] && awaddr_r == ADDR_ADC_SETUP)
					adc_setup_r[8*b +: 8] <= wdata_r[8*b +: 8];
				if (wstrb_r[b] && awaddr_r == ADDR_SHUNT_CAL)
					shunt_cal_r[8*b +: 8] <= wdata_r[8*b +: 8];
			end
			if (awaddr_r == ADDR_TEMPCO && wstrb_r[0])
				tempco_r[7:0] <= wdata_r[7:0];
			if (awaddr_r == ADDR_TEMPCO && wstrb_r[1])
				tempco_r[13:8] <= wdata_r[13:8];
		end
	end

	// Sequencer decode.
	wire logic [3:0]  mode        = adc_setup_r[ADC_MODE_LSB +: 4];
	wire logic        cont        = mode[MODE_CONT_BIT];
	wire logic [2:0]  avg_code    = adc_setup_r[ADC_AVG_LSB +: 3];
	wire logic [10:0] avg_target;
	wire logic [2:0]  ct_code;
	wire logic [17:0] ct_len;
	wire logic        ct_end      = (ct_cnt_r == ct_len - 18'd1);
	wire logic        chan_en     = (chan_r == 2'd0) ? mode[MODE_SHUNT_BIT] :
		(chan_r == 2'd1) ? mode[MODE_BUS_BIT] : mode[MODE_TEMP_BIT]; // RULE1
	wire logic        last_chan   = (chan_r == 2'd2);
	wire logic        avg_last    = (avg_cnt_r == avg_target - 11'd1);
	wire logic        dly_done    = (dly_steps_r == 8'd0) && (dly_cnt_r == 20'd0);

	// Averaging counts 1,4,16,64,128,256,512,1024.
	assign avg_target = (avg_code < 3'd4) ? (11'd1 << {avg_code, 1'b0}) :
		(11'd1 << (4'(avg_code) + 4'd3)); // RULE16
	assign ct_code    = (chan_r == 2'd0) ? adc_setup_r[ADC_VSH_LSB +: 3] :
		(chan_r == 2'd1) ? adc_setup_r[ADC_VBUS_LSB +: 3] : adc_setup_r[ADC_VT_LSB +: 3];
	// Period doubles per code step from the shortest; top code is the longest.
	assign ct_len     = (ct_code == 3'd7) ? 18'(CT_MAX_CYC) :
		(18'(CT_MIN_CYC) << ct_code); // RULE3 RULE15

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE:  state_nxt = ST_IDLE;
			ST_DELAY: if (dly_done) state_nxt = ST_CONV; // RULE23
			ST_CONV:  if (!chan_en || ct_end) state_nxt = ST_NEXT; // RULE4
			ST_NEXT:  if (last_chan) state_nxt = avg_last ? ST_LOAD : ST_CONV; // RULE5
				else state_nxt = ST_CONV;
			ST_LOAD:  state_nxt = cont ? ST_CONV : ST_IDLE; // RULE7 RULE8
			default:  state_nxt = ST_IDLE;
		endcase
		if (wr_setup)
			state_nxt = new_shut ? ST_IDLE : ST_DELAY; // RULE9
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Counters for period, channel, averaging and start delay.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || wr_setup)
		begin
			ct_cnt_r    <= 18'd0;
			chan_r      <= 2'd0;
			avg_cnt_r   <= 11'd0;
			dly_steps_r <= wr_setup ? config_r[CFG_DLY_LSB +: 8] : 8'd0;
			dly_cnt_r   <= 20'd0;
		end
		else
		begin
			if (state_r == ST_DELAY && !dly_done)
			begin
				if (dly_cnt_r == 20'd0)
				begin
					dly_cnt_r   <= 20'(DLY_STEP_CYC - 1);
					dly_steps_r <= dly_steps_r - 8'd1; // RULE14
				end
				else
					dly_cnt_r <= dly_cnt_r - 20'd1;
			end
			if (state_r == ST_CONV)
				ct_cnt_r <= (ct_end || !chan_en) ? 18'd0 : ct_cnt_r + 18'd1;
			if (state_r == ST_NEXT)
			begin
				chan_r <= last_chan ? 2'd0 : chan_r + 2'd1;
				if (last_chan)
					avg_cnt_r <= avg_last ? 11'd0 : avg_cnt_r + 11'd1;
			end
		end
	end

	// Sample accumulation; a channel's sum clears after its result loads.
	wire logic sample_take = (state_r == ST_CONV) && chan_en && ct_end;
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_acc
			always_ff @(posedge aclk)
			begin
				if (!aresetn || wr_setup || state_r == ST_LOAD)
					acc_r[g] <= 30'd0;
				else if (sample_take && chan_r == 2'(g))
					acc_r[g] <= acc_r[g] + {{10{din_r[1][19]}}, din_r[1]};
			end
		end
	endgenerate

	wire logic        single    = (avg_target == 11'd1);
	wire logic [29:0] acc_sum   = acc_r[chan_r] + {{10{din_r[1][19]}}, din_r[1]};
	wire logic [29:0] avg_val   = 30'($signed(acc_sum) >>> ((avg_code < 3'd4) ?
		{avg_code, 1'b0} : (4'(avg_code) + 4'd3)));
	wire logic        load_now  = sample_take && single && avg_last; // RULE2
	wire logic        load_avg  = sample_take && !single && avg_last && (state_r == ST_CONV);

	// Results change only on completion; reads have no effect on them.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			shunt_res_r <= 20'h00000;
			bus_res_r   <= 20'h00000;
			temp_res_r  <= 16'h0000;
			shunt_upd_r <= 1'b0;
			bus_upd_r   <= 1'b0;
		end
		else
		begin
			shunt_upd_r <= (load_now || load_avg) && chan_r == 2'd0;
			bus_upd_r   <= (load_now || load_avg) && chan_r == 2'd1;
			if (load_now || load_avg) // RULE6
			begin
				if (chan_r == 2'd0)
					shunt_res_r <= avg_val[19:0];
				if (chan_r == 2'd1)
					bus_res_r <= avg_val[19:0];
				if (chan_r == 2'd2)
					temp_res_r <= avg_val[19:4]; // RULE17
			end
		end
	end

	// Done flag: the set wins over a clear arriving in the same cycle.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			done_flag_r <= 1'b0;
		else if (state_r == ST_LOAD) // RULE10
			done_flag_r <= 1'b1;
		else if (rd_diag || (wr_setup && !new_shut)) // RULE11
			done_flag_r <= 1'b0;
	end

	logic [23:0] current_w;
	logic [23:0] power_w;
	logic [31:0] energy_w;
	logic [31:0] charge_w;
	result_math i_result_math (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.shunt_upd (shunt_upd_r),
		.bus_upd   (bus_upd_r),
		.cont_mode (cont),
		.comp_en   (config_r[CFG_COMP_BIT]),
		.shunt_res (shunt_res_r),
		.bus_res   (bus_res_r),
		.temp_res  (temp_res_r),
		.shunt_cal (shunt_cal_r),
		.tempco    (tempco_r),
		.current_r (current_w),
		.power_r   (power_w),
		.energy_r  (energy_w),
		.charge_r  (charge_w)
	);

	// Read channel.
	wire logic [31:0] rd_mux =
		(s_axi_araddr == ADDR_CONFIG)    ? {16'h0000, config_r} :
		(s_axi_araddr == ADDR_ADC_SETUP) ? {16'h0000, adc_setup_r} :
		(s_axi_araddr == ADDR_SHUNT_CAL) ? {16'h0000, shunt_cal_r} :
		(s_axi_araddr == ADDR_TEMPCO)    ? {18'h0, tempco_r} :
		(s_axi_araddr == ADDR_SHUNT_RES) ? {12'h000, shunt_res_r} :
		(s_axi_araddr == ADDR_BUS_RES)   ? {12'h000, bus_res_r} :
		(s_axi_araddr == ADDR_TEMP_RES)  ? {16'h0000, temp_res_r} :
		(s_axi_araddr == ADDR_CURRENT)   ? {8'h00, current_w} :
		(s_axi_araddr == ADDR_POWER)     ? {8'h00, power_w} :
		(s_axi_araddr == ADDR_ENERGY)    ? energy_w :
		(s_axi_araddr == ADDR_CHARGE)    ? charge_w :
		(s_axi_araddr == ADDR_DIAG)      ? {30'h0, done_flag_r, 1'b0} :
		(s_axi_araddr == ADDR_STATUS)    ? {27'h0, chan_r, state_r} : 32'h00000000;
	wire logic rd_known = (s_axi_araddr <= ADDR_STATUS) && (s_axi_araddr[1:0] == 2'b00);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			adc_channel <= 2'd0;
			adc_active  <= 1'b0;
		end
		else
		begin
			adc_channel <= chan_r;
			adc_active  <= (state_r == ST_CONV) && chan_en;
		end
	end
endmodule : power_monitor_adc_sequencer

// *** bench/power_monitor_adc_sequencer_checker.sv ***
// Bus handshake and channel assertions for the converter sequencer.
module power_monitor_adc_sequencer_checker
	import seq_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  adc_channel,
	input wire logic        adc_active
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response withdrawn early");
	chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read response changed while pending");
	chk_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	chk_wready_pulse: assert property (s_axi_wready |=> !s_axi_wready)
		else $error("wready longer than one cycle");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_read_refused: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_STATUS
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while read pending");
	chk_channel_legal: assert property (adc_active |-> adc_channel != 2'h3)
		else $error("illegal channel converting");
	chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
		!s_axi_bvalid && !s_axi_rvalid && !adc_active)
		else $error("outputs active after reset");
endmodule : power_monitor_adc_sequencer_checker

bind power_monitor_adc_sequencer power_monitor_adc_sequencer_checker i_power_monitor_adc_sequencer_checker
(
	.aclk          (aclk),
	.aresetn       (aresetn),
	.s_axi_awready (s_axi_awready),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_araddr  (s_axi_araddr),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rresp   (s_axi_rresp),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.adc_channel   (adc_channel),
	.adc_active    (adc_active)
);

// *** bench/power_monitor_adc_sequencer_tb.sv ***
// Self-checking bench for the converter sequencer.
module power_monitor_adc_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import seq_pkg::*;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [19:0] sample;
	logic [19:0] base;
	logic [1:0]  chan;
	logic        active;
	logic [31:0] rd;
	logic [1:0]  rs;
	logic [3:0]  seen;
	int          n;
	int          t_on;
	int          failures;
	int          checked;

	power_monitor_adc_sequencer i_power_monitor_adc_sequencer
	(
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (awaddr),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (awready),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (4'hf),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (wready),
		.s_axi_bresp   (bresp),
		.s_axi_bvalid  (bvalid),
		.s_axi_bready  (bready),
		.s_axi_araddr  (araddr),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (arready),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.s_axi_rvalid  (rvalid),
		.s_axi_rready  (rready),
		.adc_sample    (sample),
		.adc_channel   (chan),
		.adc_active    (active)
	);

	initial
	begin
		aclk = 1'b0;
		forever
			#20 aclk = ~aclk;
	end

	// Each channel sees its own level so results can be told apart.
	always @(posedge aclk)
		sample <= base + {18'h0, chan};

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge aclk);
		k = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			k++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid && k < 50);
		rs = bresp;
		bready <= 1'b0;
		if (k >= 50)
			failures++;
	endtask : wr

	task automatic rdreg(input logic [7:0] a);
		int k;
		@(posedge aclk);
		k = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			k++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid && k < 50);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (k >= 50)
			failures++;
	endtask : rdreg

	// Waits for a sequence; idle gaps between channels or passes are not its end.
	task automatic run(input int lim);
		int q;
		q = 0;
		n = 0;
		while (!active && n < lim)
		begin
			@(posedge aclk);
			n++;
		end
		t_on = n;
		while (q < 8 && n < lim)
		begin
			@(posedge aclk);
			n++;
			q = active ? 0 : q + 1;
			if (active)
				seen = seen | (4'h1 << chan);
		end
		n = n - 8 - t_on;
		if (q < 8)
			failures++;
	endtask : run

	task automatic t_reset();
		rdreg(ADDR_ADC_SETUP);
		check(rd, {16'h0, ADC_SETUP_RESET}, "setup reset");
		rdreg(ADDR_CONFIG);
		check({24'h0, rd[13:6]}, 32'h0, "delay reset");
		rdreg(8'h40);
		check(rd, 32'h0, "unmapped read data");
		check({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped read");
		wr(8'h44, 32'hffff);
		check({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write");
		wr(ADDR_SHUNT_CAL, 32'h0);
	endtask : t_reset

	task automatic t_single();
		wr(ADDR_ADC_SETUP, 32'h2000);
		seen = 4'h0;
		run(3000);
		check(32'(t_on <= 4), 32'h1, "start latency");
		check(32'(n >= 1249 && n <= 1262), 32'h1, "shunt period");
		check({28'h0, seen}, 32'h1, "shunt only");
		rdreg(ADDR_BUS_RES);
		check(rd, 32'h0, "bus untouched");
		rdreg(ADDR_SHUNT_RES);
		check(32'(rd != 0), 32'h1, "shunt updated");
		rdreg(ADDR_DIAG);
		check(32'(rd[DIAG_DONE_BIT]), 32'h1, "done set");
		rdreg(ADDR_DIAG);
		check(32'(rd[DIAG_DONE_BIT]), 32'h0, "done read clear");
		repeat (1300) @(posedge aclk);
		check({31'h0, active}, 32'h0, "stays shut down");
	endtask : t_single

	task automatic t_three();
		wr(ADDR_ADC_SETUP, 32'h7000);
		seen = 4'h0;
		run(6000);
		check(32'(n >= 3749 && n <= 3785), 32'h1, "sequence length");
		check({28'h0, seen}, 32'h7, "all channels");
		rdreg(ADDR_TEMP_RES);
		check(32'(rd != 0), 32'h1, "temperature stored");
		rdreg(ADDR_POWER);
		check(rd, 32'h0, "power zero");
		rdreg(ADDR_CHARGE);
		check(rd, 32'h0, "charge zero");
	endtask : t_three

	task automatic t_cont();
		wr(ADDR_ADC_SETUP, 32'ha000);
		rdreg(ADDR_DIAG);
		check(32'(rd[DIAG_DONE_BIT]), 32'h0, "done write clear");
		repeat (2600) @(posedge aclk);
		check({31'h0, active}, 32'h1, "continuous repeat");
		rdreg(ADDR_DIAG);
		check(32'(rd[DIAG_DONE_BIT]), 32'h1, "done continuous");
		wr(ADDR_ADC_SETUP, 32'h1000);
		seen = 4'h0;
		run(3000);
		check(32'(n >= 1249 && n <= 1262), 32'h1, "abort restart");
		check({28'h0, seen}, 32'h2, "new mode used");
		wr(ADDR_ADC_SETUP, 32'h0);
		rdreg(ADDR_DIAG);
		check(32'(rd[DIAG_DONE_BIT]), 32'h1, "shutdown keeps done");
	endtask : t_cont

	task automatic t_avg();
		logic [31:0] old;
		rdreg(ADDR_SHUNT_RES);
		old = rd;
		base <= 20'h0a5a0;
		wr(ADDR_ADC_SETUP, 32'h2200);
		repeat (1400) @(posedge aclk);
		check({31'h0, active}, 32'h1, "averaging repeats");
		rdreg(ADDR_SHUNT_RES);
		check(rd, old, "result held");
		rdreg(ADDR_DIAG);
		check(32'(rd[DIAG_DONE_BIT]), 32'h0, "done early");
		run(30000);
		rdreg(ADDR_SHUNT_RES);
		check(32'(rd != old), 32'h1, "average written");
		rdreg(ADDR_DIAG);
		check(32'(rd[DIAG_DONE_BIT]), 32'h1, "done averaged");
	endtask : t_avg

	// Charge sums the previous current, so two shunt passes must pass first.
	task automatic t_math();
		logic [31:0] old;
		wr(ADDR_SHUNT_CAL, 32'h4000);
		wr(ADDR_ADC_SETUP, 32'hb000);
		repeat (4000) @(posedge aclk);
		rdreg(ADDR_POWER);
		check(32'(rd != 0), 32'h1, "power after bus");
		rdreg(ADDR_ENERGY);
		check(32'(rd != 0), 32'h1, "energy accumulates");
		wr(ADDR_ADC_SETUP, 32'h3000);
		rdreg(ADDR_CHARGE);
		old = rd;
		check(32'(rd != 0), 32'h1, "charge accumulates");
		seen = 4'h0;
		run(6000);
		check({28'h0, seen}, 32'h3, "shunt and bus");
		rdreg(ADDR_CHARGE);
		check(rd, old, "no triggered charge");
	endtask : t_math

	// One 2 ms step costs 50000 cycles, the longest part of the run.
	task automatic t_delay();
		wr(ADDR_CONFIG, 32'h40);
		wr(ADDR_ADC_SETUP, 32'h2000);
		run(53000);
		check(32'(t_on >= 49985 && t_on <= 50010), 32'h1, "start delay");
		check(32'(n >= 1249 && n <= 1262), 32'h1, "delayed period");
		wr(ADDR_CONFIG, 32'h0);
	endtask : t_delay

	initial
	begin
		repeat (100000) @(posedge aclk);
		failures++;
		give_verdict();
	end

	initial
	begin
		failures = 0;
		checked = 0;
		aresetn = 1'b0;
		awaddr = 8'h0;
		awvalid = 1'b0;
		wdata = 32'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h0;
		arvalid = 1'b0;
		rready = 1'b0;
		base = 20'h12340;
		sample = 20'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_single();
		t_three();
		t_cont();
		t_avg();
		t_math();
		t_delay();
		give_verdict();
	end
endmodule : power_monitor_adc_sequencer_tb
